// [rrs_pkg.sv]
package rrs_pkg;

    // widths
    localparam int DATA_W  = 8;
    localparam int PC_W    = 11;
    localparam int SP_W    = 3;
    localparam int FADDR_W = 7;
    localparam int OP_W    = 3;

    // instruction cycle counts
    localparam logic [1:0] CYC_RET  = 2'h2;
    localparam logic [1:0] CYC_ALU  = 2'h1;

    // bit positions
    localparam int MSB_POS  = 7;
    localparam int LSB_POS  = 0;
    localparam int HALF_POS = 4;

    // destination select encodings
    localparam logic DEST_WORK = 1'h0;
    localparam logic DEST_FILE = 1'h1;

    // value loaded into the global enable on interrupt exit
    localparam logic GIE_SET = 1'h1;

    // reset values
    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST   = 11'h000;

    typedef enum logic [OP_W-1:0] {
        RRS_NOP,
        RRS_SUB_EXIT,
        RRS_IRQ_EXIT,
        RRS_ROT_LEFT,
        RRS_ROT_RIGHT,
        RRS_SUB_BORROW
    } rrs_op_type;

    // one decoded instruction
    typedef struct packed {
        rrs_op_type          op;
        logic [FADDR_W-1:0]  faddr;
        logic                dest;
    } rrs_instr_type;

    // status flags touched here
    typedef struct packed {
        logic zero;
        logic half_carry_flag;
        logic carry;
    } rrs_flags_type;

    // file register write request
    typedef struct packed {
        logic               we;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0]  data;
    } rrs_fwrite_type;

endpackage

// [rrs_alu.sv]
`timescale 1ns/100ps
module rrs_alu (
    input  wire rrs_pkg::rrs_op_type          op,
    input  wire logic [rrs_pkg::DATA_W-1:0]   file_val,
    input  wire logic [rrs_pkg::DATA_W-1:0]   work_val,
    input  wire rrs_pkg::rrs_flags_type       flags_in,
    output logic [rrs_pkg::DATA_W-1:0]        result,
    output rrs_pkg::rrs_flags_type            flags_out
);
    logic [rrs_pkg::HALF_POS:0] low_sum;
    logic [rrs_pkg::DATA_W:0]   full_sum;

    // subtract as file + ~work + carry
    assign low_sum  = {1'b0, file_val[rrs_pkg::HALF_POS-1:0]} + {1'b0, ~work_val[rrs_pkg::HALF_POS-1:0]}
                      + {{rrs_pkg::HALF_POS{1'b0}}, flags_in.carry};
    assign full_sum = {1'b0, file_val} + {1'b0, ~work_val} + {{rrs_pkg::DATA_W{1'b0}}, flags_in.carry};

    // result and flags per operation
    always_comb begin
        result    = file_val;
        flags_out = flags_in;
        case (op)
            rrs_pkg::RRS_ROT_LEFT: begin
                result          = {file_val[rrs_pkg::MSB_POS-1:0], flags_in.carry};
                flags_out.carry = file_val[rrs_pkg::MSB_POS];
            end
            rrs_pkg::RRS_ROT_RIGHT: begin
                result          = {flags_in.carry, file_val[rrs_pkg::MSB_POS:1]};
                flags_out.carry = file_val[rrs_pkg::LSB_POS];
            end
            rrs_pkg::RRS_SUB_BORROW: begin
                result                    = full_sum[rrs_pkg::DATA_W-1:0];
                flags_out.carry           = full_sum[rrs_pkg::DATA_W];
                flags_out.half_carry_flag = low_sum[rrs_pkg::HALF_POS];
                flags_out.zero            = (full_sum[rrs_pkg::DATA_W-1:0] == 8'h00);
            end
            default: begin
                result    = file_val;
                flags_out = flags_in;
            end
        endcase
    end
endmodule

// [rrs_exec.sv]
// Summary of operation
// - interrupt exit loads pc, sets global enable
// - returns read stack top, then decrement pointer
// - subroutine exit: pc from stack, flags kept, 2 cycles
// - rotate left: carry in bit0, bit7 out
// - rotate right: carry in bit7, bit0 out
// - dest 0 writes working register, 1 file
// - rotates and subtract one cycle; rotates alter carry
// - subtract: file plus inverted work plus carry
// - carry is inverted borrow; zero on zero
`timescale 1ns/100ps
module rrs_exec (
    input  wire logic                           sys_clk,
    input  wire logic                           rstn,
    input  wire logic                           instr_valid,
    input  wire rrs_pkg::rrs_instr_type         instr,
    input  wire logic [rrs_pkg::DATA_W-1:0]     file_rdata,
    input  wire logic [rrs_pkg::PC_W-1:0]       stack_top,
    input  wire logic [rrs_pkg::SP_W-1:0]       stack_ptr_in,
    input  wire rrs_pkg::rrs_flags_type         flags_in,
    output logic                                busy,
    output logic                                done,
    output logic [rrs_pkg::DATA_W-1:0]          working_register,
    output rrs_pkg::rrs_fwrite_type             file_write,
    output rrs_pkg::rrs_flags_type              flags_out,
    output logic                                flags_we,
    output logic [rrs_pkg::PC_W-1:0]            pc_load_val,
    output logic                                pc_load,
    output logic [rrs_pkg::SP_W-1:0]            stack_ptr_out,
    output logic                                stack_ptr_we,
    output logic                                global_irq_enable_set
);
    typedef enum logic [1:0] {
        RRS_IDLE,
        RRS_RET_WAIT
    } rrs_state_type;

    rrs_state_type                 state;
    rrs_state_type                 next_state;
    logic [rrs_pkg::DATA_W-1:0]    alu_result;
    rrs_pkg::rrs_flags_type        alu_flags;
    logic [rrs_pkg::DATA_W-1:0]    next_working_register;
    rrs_pkg::rrs_fwrite_type       next_file_write;
    rrs_pkg::rrs_flags_type        next_flags_out;
    logic                          next_flags_we;
    logic [rrs_pkg::PC_W-1:0]      next_pc_load_val;
    logic                          next_pc_load;
    logic [rrs_pkg::SP_W-1:0]      next_stack_ptr_out;
    logic                          next_stack_ptr_we;
    logic                          next_gie_set;
    logic                          next_busy;
    logic                          next_done;
    logic                          is_alu;

    // shared rotate and subtract datapath
    rrs_alu u_alu (
        .op        (instr.op),
        .file_val  (file_rdata),
        .work_val  (working_register),
        .flags_in  (flags_in),
        .result    (alu_result),
        .flags_out (alu_flags)
    );

    assign is_alu = instr_valid && (instr.op == rrs_pkg::RRS_ROT_LEFT || instr.op == rrs_pkg::RRS_ROT_RIGHT
                    || instr.op == rrs_pkg::RRS_SUB_BORROW);

    // decoded requests; nothing is taken during a return's wait cycle
    logic                          is_ret;
    logic                          is_irq;
    logic                          in_idle;
    logic                          alu_taken;
    logic                          ret_taken;
    logic [rrs_pkg::SP_W-1:0]      popped_ptr;

    // qualify requests by the sequencing state
    assign is_ret    = instr_valid && (instr.op == rrs_pkg::RRS_SUB_EXIT
                       || instr.op == rrs_pkg::RRS_IRQ_EXIT);
    assign is_irq    = (instr.op == rrs_pkg::RRS_IRQ_EXIT);
    assign in_idle   = (state == RRS_IDLE);
    assign alu_taken = is_alu && in_idle;
    assign ret_taken = is_ret && in_idle;

    // pointer after the pop, wraps at the bottom of the stack
    assign popped_ptr = stack_ptr_in - 3'h1;

    // sequencing: a return holds one wait cycle before done
    always_comb begin
        next_state = state;
        next_busy  = 1'b0;
        next_done  = 1'b0;
        case (state)
            RRS_IDLE: begin
                // nop and unused codes leave the block idle
                if (alu_taken) begin
                    next_done = 1'b1;
                end else if (ret_taken) begin
                    next_busy  = 1'b1;
                    next_state = RRS_RET_WAIT;
                end
            end
            RRS_RET_WAIT: begin
                // any request seen here is refused
                next_done  = 1'b1;
                next_state = RRS_IDLE;
            end
            default: begin
                next_state = RRS_IDLE;
            end
        endcase
    end

    // sequencing registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state <= RRS_IDLE;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            state <= next_state;
            busy  <= next_busy;
            done  <= next_done;
        end
    end

    // working register takes results whose destination select is 0
    always_comb begin
        next_working_register = working_register;
        if (alu_taken && instr.dest == rrs_pkg::DEST_WORK) begin
            next_working_register = alu_result;
        end
    end

    // working register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            working_register <= rrs_pkg::WORK_RST;
        end else begin
            working_register <= next_working_register;
        end
    end

    // file write request for destination select 1, one cycle wide
    always_comb begin
        next_file_write = '0;
        if (alu_taken && instr.dest == rrs_pkg::DEST_FILE) begin
            next_file_write.we   = 1'b1;
            next_file_write.addr = instr.faddr;
            next_file_write.data = alu_result;
        end
    end

    // file write request register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            file_write <= '0;
        end else begin
            file_write <= next_file_write;
        end
    end

    // status flags follow the datapath; returns leave them alone
    always_comb begin
        next_flags_out = flags_out;
        next_flags_we  = 1'b0;
        if (alu_taken) begin
            next_flags_out = alu_flags;
            next_flags_we  = 1'b1;
        end else if (ret_taken) begin
            next_flags_we = 1'b0;
        end
    end

    // status flag registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            flags_out <= '0;
            flags_we  <= 1'b0;
        end else begin
            flags_out <= next_flags_out;
            flags_we  <= next_flags_we;
        end
    end

    // program counter reload and stack pop on returns, global enable on interrupt exit only
    always_comb begin
        next_pc_load_val   = pc_load_val;
        next_pc_load       = 1'b0;
        next_stack_ptr_out = stack_ptr_out;
        next_stack_ptr_we  = 1'b0;
        next_gie_set       = 1'b0;
        if (ret_taken) begin
            next_pc_load_val   = stack_top;
            next_pc_load       = 1'b1;
            next_stack_ptr_out = popped_ptr;
            next_stack_ptr_we  = 1'b1;
            if (is_irq) begin
                next_gie_set = rrs_pkg::GIE_SET;
            end
        end
    end

    // program counter and stack registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pc_load_val           <= rrs_pkg::PC_RST;
            pc_load               <= 1'b0;
            stack_ptr_out         <= '0;
            stack_ptr_we          <= 1'b0;
            global_irq_enable_set <= 1'b0;
        end else begin
            pc_load_val           <= next_pc_load_val;
            pc_load               <= next_pc_load;
            stack_ptr_out         <= next_stack_ptr_out;
            stack_ptr_we          <= next_stack_ptr_we;
            global_irq_enable_set <= next_gie_set;
        end
    end
endmodule

// [rrs_exec_checker.sv]
`timescale 1ns/100ps
module rrs_exec_checker (
    input wire logic                  sys_clk,
    input wire logic                  rstn,
    input wire logic                  instr_valid,
    input wire rrs_pkg::rrs_instr_type instr,
    input wire logic [7:0]            file_rdata,
    input wire logic [10:0]           stack_top,
    input wire logic [2:0]            stack_ptr_in,
    input wire rrs_pkg::rrs_flags_type flags_in,
    input wire logic                  done,
    input wire logic [7:0]            working_register,
    input wire rrs_pkg::rrs_fwrite_type file_write,
    input wire rrs_pkg::rrs_flags_type flags_out,
    input wire logic                  flags_we,
    input wire logic [10:0]           pc_load_val,
    input wire logic                  pc_load,
    input wire logic [2:0]            stack_ptr_out,
    input wire logic                  stack_ptr_we,
    input wire logic                  global_irq_enable_set
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic       wt;
    wire        tk  = instr_valid && !wt;
    wire        ex  = instr.op inside {rrs_pkg::RRS_SUB_EXIT, rrs_pkg::RRS_IRQ_EXIT};
    wire        al  = instr.op >= rrs_pkg::RRS_ROT_LEFT;
    wire [7:0]  res = file_write.we ? file_write.data : working_register;
    // marks the wait cycle of a return
    always_ff @(posedge sys_clk) begin
        wt <= rstn && tk && ex;
    end
    property p_gie;
        tk && instr.op == rrs_pkg::RRS_IRQ_EXIT |=> global_irq_enable_set && pc_load;
    endproperty
    a_gie: assert property (p_gie) else $error("irq exit without enable");
    property p_pop;
        tk && ex |=> stack_ptr_we && stack_ptr_out == $past(stack_ptr_in) - 3'h1 && pc_load_val == $past(stack_top);
    endproperty
    a_pop: assert property (p_pop) else $error("bad stack pop");
    property p_two;
        tk && ex |=> !done && !flags_we ##1 done && !flags_we;
    endproperty
    a_two: assert property (p_two) else $error("return timing wrong");
    property p_rotl;
        tk && instr.op == rrs_pkg::RRS_ROT_LEFT |=> res == {$past(file_rdata[6:0]), $past(flags_in.carry)}
            && flags_out == {$past(flags_in[2:1]), $past(file_rdata[7])};
    endproperty
    a_rotl: assert property (p_rotl) else $error("rotate left wrong");
    property p_rotr;
        tk && instr.op == rrs_pkg::RRS_ROT_RIGHT |=> res == {$past(flags_in.carry), $past(file_rdata[7:1])}
            && flags_out == {$past(flags_in[2:1]), $past(file_rdata[0])};
    endproperty
    a_rotr: assert property (p_rotr) else $error("rotate right wrong");
    property p_dest;
        tk && al |=> done && flags_we && file_write.we == $past(instr.dest)
            && (!file_write.we || file_write.addr == $past(instr.faddr));
    endproperty
    a_dest: assert property (p_dest) else $error("bad destination");
    property p_sub;
        tk && instr.op == rrs_pkg::RRS_SUB_BORROW |=> flags_out.zero == (res == 8'h00) && {flags_out.carry, res}
            == {1'b0, $past(file_rdata)} + {1'b0, ~$past(working_register)} + $past(flags_in.carry);
    endproperty
    a_sub: assert property (p_sub) else $error("subtract wrong");
    property p_half;
        tk && instr.op == rrs_pkg::RRS_SUB_BORROW |=> flags_out.half_carry_flag == (({1'b0, $past(file_rdata[3:0])}
            + {1'b0, ~$past(working_register[3:0])} + $past(flags_in.carry)) > 5'h0f);
    endproperty
    a_half: assert property (p_half) else $error("half carry wrong");
    c_irq: cover property (tk && instr.op == rrs_pkg::RRS_IRQ_EXIT);
    c_sub: cover property (tk && instr.op == rrs_pkg::RRS_SUB_BORROW && instr.dest);
    c_refused: cover property (instr_valid && wt);
endmodule
bind rrs_exec rrs_exec_checker rrs_exec_checker_inst (.sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr(instr), .file_rdata(file_rdata), .stack_top(stack_top), .stack_ptr_in(stack_ptr_in), .flags_in(flags_in),
    .done(done), .working_register(working_register), .file_write(file_write), .flags_out(flags_out),
    .flags_we(flags_we), .pc_load_val(pc_load_val), .pc_load(pc_load), .stack_ptr_out(stack_ptr_out),
    .stack_ptr_we(stack_ptr_we), .global_irq_enable_set(global_irq_enable_set));

// [return_rotate_subtract_exec_test.sv]
`timescale 1ns/100ps
module return_rotate_subtract_exec_test;
    logic                    sys_clk, rstn, instr_valid, busy, done, flags_we, pc_load, stack_ptr_we, global_irq_enable;
    rrs_pkg::rrs_instr_type  instr;
    rrs_pkg::rrs_flags_type  flags_in, flags_out, f;
    rrs_pkg::rrs_fwrite_type file_write;
    logic [7:0]              file_rdata, working_register, work, res;
    logic [10:0]             stack_top, pc_load_val;
    logic [2:0]              stack_ptr_in, stack_ptr_out;
    logic [8:0]              s9;
    logic [4:0]              h5;
    logic [11:0]             q[$];
    logic [14:0]             r[$];
    integer                  seed, num_errors, checks_done, i;
    rrs_exec rrs_exec_inst (.sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
        .file_rdata(file_rdata), .stack_top(stack_top), .stack_ptr_in(stack_ptr_in), .flags_in(flags_in),
        .busy(busy), .done(done), .working_register(working_register),
        .file_write(file_write), .flags_out(flags_out), .flags_we(flags_we), .pc_load_val(pc_load_val),
        .pc_load(pc_load), .stack_ptr_out(stack_ptr_out), .stack_ptr_we(stack_ptr_we), .global_irq_enable_set(global_irq_enable));
    // clock generator
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task chk(input logic ok);
        checks_done++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: output differs from expected", $time);
        end
    endtask
    task report_and_stop;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // drives one instruction and notes its expected result
    task issue(input rrs_pkg::rrs_op_type op, input logic d, input logic refuse);
        @(negedge sys_clk);
        instr_valid = 1'b1;
        instr.op = op;
        instr.dest = d;
        {file_rdata, stack_top, stack_ptr_in, flags_in, instr.faddr} = $random(seed);
        res = {file_rdata[6:0], flags_in.carry};
        f = {flags_in[2:1], file_rdata[7]};
        if (op == rrs_pkg::RRS_ROT_RIGHT) begin
            res = {flags_in.carry, file_rdata[7:1]};
            f = {flags_in[2:1], file_rdata[0]};
        end
        if (op == rrs_pkg::RRS_SUB_BORROW) begin
            s9 = {1'b0, file_rdata} + {1'b0, ~work} + flags_in.carry;
            h5 = {1'b0, file_rdata[3:0]} + {1'b0, ~work[3:0]} + flags_in.carry;
            res = s9[7:0];
            f = {res == 8'h00, h5[4], s9[8]};
        end
        if (op >= rrs_pkg::RRS_ROT_LEFT) begin
            q.push_back({d, res, f});
            if (!d) work = res;
        end else if (op != rrs_pkg::RRS_NOP) begin
            r.push_back({stack_top, stack_ptr_in - 3'h1, op == rrs_pkg::RRS_IRQ_EXIT});
            @(negedge sys_clk);
            instr_valid = refuse;
            instr.op = rrs_pkg::RRS_SUB_BORROW;
            @(negedge sys_clk);
            instr_valid = 1'b0;
        end
    endtask
    // compares each result against the oldest note
    always @(negedge sys_clk) begin
        if (rstn && flags_we) chk({file_write.we, file_write.we ? file_write.data : working_register, flags_out}
            === q.pop_front());
        if (rstn && pc_load) chk({pc_load_val, stack_ptr_out, global_irq_enable, stack_ptr_we, busy, flags_we}
            === {r.pop_front(), 3'h6});
    end
    // reset, random instruction stream, drain
    initial begin
        {rstn, instr_valid, instr, file_rdata, stack_top, stack_ptr_in, flags_in} = '0;
        seed = 13;
        num_errors = 0;
        checks_done = 0;
        work = rrs_pkg::WORK_RST;
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk) rstn = 1'b1;
        for (i = 0; i < 400; i++) begin
            issue(rrs_pkg::rrs_op_type'(3'($unsigned($random(seed)) % 6)), 1'($random(seed)), 1'($random(seed)));
        end
        @(negedge sys_clk) instr_valid = 1'b0;
        for (i = 0; i < 20 && q.size() + r.size() > 0; i++) @(negedge sys_clk);
        if (q.size() + r.size() > 0) num_errors++;
        report_and_stop();
    end
endmodule
